// ---- hdl/serial_rx_slave.v ----
/*
 * Write-only two-wire slave receiver. Finds start and stop conditions,
 * shifts bits MSB first, acknowledges the first ten bytes when the address matches, reports each
 * bit of the address byte and of acknowledged bytes with its byte position. Assumes clock and data inputs are already
 * synchronised to sys_clk; the data line is open drain with a pull-up.
 */
`timescale 1ns/1ps
`include "clock_fanout_defines.vh"

module serial_rx_slave (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       sys_rst,
    // Synchronised bus lines
    input  wire       sclSync,
    input  wire       sdaSync,
    // Data line drive
    output reg        sdaOut,
    output reg        sdaOe,
    // Received bit report
    output reg        bitValid,
    output reg  [3:0] bitByte,
    output reg  [2:0] bitIndex,
    output reg        bitValue,
    // Frame state
    output reg        addrOk,
    output reg        frameEnd
);

    localparam IDLE = 2'h0;
    localparam RECV = 2'h1;
    localparam ACK  = 2'h2;

    reg [1:0] state_q;
    reg       sclPrev_q;
    reg       sdaPrev_q;
    reg [2:0] bitCnt_q;
    reg [7:0] shift_q;
    reg [3:0] byteCnt_q;
    reg       pend_q;
    reg       pendValue_q;

    wire sclRise = sclSync & ~sclPrev_q;
    wire sclFall = ~sclSync & sclPrev_q;
    wire startCond = sclSync & sclPrev_q & sdaPrev_q & ~sdaSync;
    wire stopCond  = sclSync & sclPrev_q & ~sdaPrev_q & sdaSync;
    wire [7:0] shiftNext = {shift_q[6:0], sdaSync};

    // Frame sequencer: bits are sampled on clock rise, ack driven after fall
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= IDLE;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            bitCnt_q  <= 3'h0;
            shift_q   <= 8'h00;
            byteCnt_q <= 4'h0;
            pend_q      <= 1'b0;
            pendValue_q <= 1'b0;
            sdaOut    <= 1'b0;
            sdaOe     <= 1'b0;
            bitValid  <= 1'b0;
            bitByte   <= 4'h0;
            bitIndex  <= 3'h0;
            bitValue  <= 1'b0;
            addrOk    <= 1'b0;
            frameEnd  <= 1'b0;
        end else begin
            sclPrev_q <= sclSync;
            sdaPrev_q <= sdaSync;
            bitValid  <= 1'b0;
            frameEnd  <= 1'b0;
            if (startCond | stopCond) begin
                // Early stop or restart ends the frame; settings stay
                state_q   <= startCond ? RECV : IDLE;
                bitCnt_q  <= 3'h0;
                byteCnt_q <= 4'h0;
                addrOk    <= 1'b0;
                sdaOe     <= 1'b0;
                frameEnd  <= 1'b1;
                pend_q    <= 1'b0; // Cut pulse is no bit: later enables
            end else begin
                case (state_q)
                    IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    RECV: begin
                        if (sclRise) begin
                            // Capture MSB first, bit 7 leads; commit waits for the fall
                            shift_q     <= shiftNext;
                            pendValue_q <= sdaSync;
                            pend_q      <= 1'b1;
                        end else if (sclFall & pend_q) begin
                            // Pulse ended with no start or stop: the bit is real
                            pend_q   <= 1'b0;
                            bitCnt_q <= bitCnt_q + 3'h1;
                            bitValid <= 1'b1;
                            bitByte  <= byteCnt_q;
                            bitIndex <= 3'h7 - bitCnt_q;
                            bitValue <= pendValue_q;
                            if (bitCnt_q == 3'h7) begin
                                state_q <= ACK;
                                sdaOut  <= 1'b0;
                                if (byteCnt_q == 4'h0) begin
                                    addrOk <= (shift_q == `CF_SLAVE_ADDR);
                                    sdaOe  <= (shift_q == `CF_SLAVE_ADDR);
                                end else begin
                                    sdaOe <= addrOk;
                                end
                            end
                        end
                    end
                    ACK: begin
                        if (sclFall) begin
                            // Ninth pulse over: release, then next byte or rest
                            sdaOe     <= 1'b0;
                            state_q   <= (~addrOk | (byteCnt_q == `CF_BYTE_LAST)) ? IDLE : RECV;
                            byteCnt_q <= byteCnt_q + 4'h1;
                        end
                    end
                    default: state_q <= IDLE;
                endcase
            end
        end
    end

endmodule // serial_rx_slave

// ---- pkg/clock_fanout_defines.vh ----
/*
 * Constants of the clock fan-out output control: serial slave address,
 * byte positions of the configuration write, enable bit map, reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef CLOCK_FANOUT_DEFINES_VH
`define CLOCK_FANOUT_DEFINES_VH

`define CF_NUM_OUTPUTS     10
`define CF_SLAVE_ADDR      8'hd2
`define CF_BYTE_FIRST_DATA 4'h3
`define CF_BYTE_LAST_CFG   4'h5
`define CF_BYTE_LAST       4'h9
`define CF_EN_RESET        10'h3ff
`define CF_D0_LSB          3'h0
`define CF_D1_LSB          3'h4
`define CF_D2_LSB          3'h6
`define CF_D2_OUT          4'h8

`endif

// ---- hdl/clock_fanout_ctrl.v ----
/*
 * Output control of a ten-output clock fan-out buffer with a serial
 * two-wire configuration port. Assumes the reference clock, output-enable
 * pin and bus lines arrive asynchronously to sys_clk and are resampled
 * here; the output copies are therefore delayed by the synchroniser.
 */
`timescale 1ns/1ps
`include "clock_fanout_defines.vh"

module clock_fanout_ctrl (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       sys_rst,
    // Reference clock and global enable pin
    input  wire       refClk,
    input  wire       outEnable,
    // Serial two-wire port
    input  wire       serial_clock_line,
    input  wire       serial_data_line_in,
    output wire       serial_data_line_out,
    output wire       serial_data_line_oe,
    // Clock outputs with enables
    output reg  [9:0] clock_outputs,
    output reg  [9:0] clock_outputs_oe,
    // Status
    output wire [9:0] outEnables
);

    reg [1:0] refSync_q;
    reg [1:0] oeSync_q;
    reg [1:0] sclSync_q;
    reg [1:0] sdaSync_q;
    reg [9:0] enable_q;

    wire       bitValid;
    wire [3:0] bitByte;
    wire [2:0] bitIndex;
    wire       bitValue;
    wire       addrOk;

    // Two-flop synchronisers for all pins
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            refSync_q <= 2'h0;
            oeSync_q  <= 2'h0;
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
        end else begin
            refSync_q <= {refSync_q[0], refClk};
            oeSync_q  <= {oeSync_q[0], outEnable};
            sclSync_q <= {sclSync_q[0], serial_clock_line};
            sdaSync_q <= {sdaSync_q[0], serial_data_line_in};
        end
    end

    serial_rx_slave rx (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .sclSync  (sclSync_q[1]),
        .sdaSync  (sdaSync_q[1]),
        .sdaOut   (serial_data_line_out),
        .sdaOe    (serial_data_line_oe),
        .bitValid (bitValid),
        .bitByte  (bitByte),
        .bitIndex (bitIndex),
        .bitValue (bitValue),
        .addrOk   (addrOk),
        .frameEnd ()
    );

    // Enable bits load one by one as they arrive
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_q <= `CF_EN_RESET;
        end else if (bitValid & addrOk) begin
            // Command and count bytes (1,2) and bytes past 5 fall through
            case (bitByte)
                `CF_BYTE_FIRST_DATA: if (bitIndex < `CF_D1_LSB)
                          enable_q[bitIndex] <= bitValue;
                `CF_BYTE_FIRST_DATA + 4'h1: if (bitIndex >= `CF_D1_LSB)
                          enable_q[bitIndex] <= bitValue;
                `CF_BYTE_LAST_CFG: if (bitIndex >= `CF_D2_LSB)
                          enable_q[{1'b0, bitIndex} - {1'b0, `CF_D2_LSB} + `CF_D2_OUT]
                              <= bitValue;
                default: enable_q <= enable_q;
            endcase
        end
    end

    assign outEnables = enable_q;

    // Output copies: pin low floats, enable zero drives low
    genvar i;
    generate
        for (i = 0; i < `CF_NUM_OUTPUTS; i = i + 1) begin : g_out
            always @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    clock_outputs[i]    <= 1'b0;
                    clock_outputs_oe[i] <= 1'b0;
                end else begin
                    clock_outputs_oe[i] <= oeSync_q[1];
                    clock_outputs[i]    <= oeSync_q[1] & enable_q[i] & refSync_q[1];
                end
            end
        end
    endgenerate

endmodule // clock_fanout_ctrl

// ---- verification/clock_fanout_monitor.sv ----
/* Port checker for the clock fan-out output control.
   Assumes binding to clock_fanout_ctrl and one clock domain. */
`timescale 1ns/1ps
module clock_fanout_monitor (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Pins
    input wire logic       refClk,
    input wire logic       outEnable,
    input wire logic       serial_data_line_out,
    input wire logic       serial_data_line_oe,
    // Outputs and enables
    input wire logic [9:0] clock_outputs,
    input wire logic [9:0] clock_outputs_oe,
    input wire logic [9:0] outEnables
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Pin held low, acknowledge held
    sequence s_pin_low; (!outEnable) [*4]; endsequence
    sequence s_ack_hold; serial_data_line_oe [*6]; endsequence
    a_pin_low_quiet: assert property (s_pin_low |->
        clock_outputs_oe == 10'h0 && clock_outputs == 10'h0) else $error("active with pin low");
    a_pin_high_drive: assert property ((outEnable && !sys_rst) [*4] |->
        clock_outputs_oe == 10'h3ff) else $error("not driven with pin high");
    a_oe_all_same: assert property (
        clock_outputs_oe == 10'h0 || clock_outputs_oe == 10'h3ff) else $error("mixed enables");
    a_disabled_low: assert property (((clock_outputs & ~(outEnables | $past(outEnables)
        | $past(outEnables, 2) | $past(outEnables, 3))) == 10'h0)) else $error("disabled toggles");
    a_ref_follow: assert property ($rose(refClk) ##0
        (outEnable && outEnables[0]) [*5] |-> clock_outputs[0]) else $error("output not copying");
    a_reset_enables: assert property ($fell(sys_rst) |->
        outEnables == 10'h3ff) else $error("enables not set after reset");
    a_ack_low: assert property (serial_data_line_oe |->
        !serial_data_line_out) else $error("acknowledge not low");
    a_ack_length: assert property ($rose(serial_data_line_oe) |->
        s_ack_hold ##[1:6] !serial_data_line_oe) else $error("acknowledge length wrong");
endmodule // clock_fanout_monitor

bind clock_fanout_ctrl clock_fanout_monitor clock_fanout_monitor_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .refClk(refClk), .outEnable(outEnable),
    .serial_data_line_out(serial_data_line_out), .serial_data_line_oe(serial_data_line_oe),
    .clock_outputs(clock_outputs), .clock_outputs_oe(clock_outputs_oe), .outEnables(outEnables));

// ---- verification/bus_master_model.sv ----
/* Two-wire bus master model sending configuration writes.
   Assumes the bench resolves a pulled-up data wire. */
`timescale 1ns/1ps
module bus_master_model (
    // Bus lines
    output logic      scl,
    output logic      sdaLow,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    // One 320 ns bit slot; data moves only while clock low
    task automatic slot(input logic b, output logic seen);
        sdaLow = !b;
        #80 scl = 1'b1;
        #80 seen = sda;
        #80 scl = 1'b0;
        #80;
    endtask
    // Start, n bytes MSB first each with ack slot, then stop
    task automatic frame(input logic [79:0] d, input int n, output logic [9:0] acks);
        logic s;
        acks = 10'h0;
        sdaLow = 1'b1;
        #160 scl = 1'b0;
        #80;
        for (int i = 0; i < n; i++) begin
            for (int k = 0; k < 8; k++) slot(d[79 - 8 * i - k], s);
            slot(1'b1, s);
            acks[9 - i] = !s;
        end
        sdaLow = 1'b1;
        #80 scl = 1'b1;
        #160 sdaLow = 1'b0;
        #320;
    endtask
endmodule // bus_master_model

// ---- verification/tb_top.sv ----
/* Self-checking bench for the clock fan-out output control.
   Assumes the bus master model and the bound port checker. */
`timescale 1ns/1ps
module tb_top;
    logic       sys_clk, sys_rst, refClk, outEnable;
    wire logic  scl, sdaLow, sda, sdaOut, sdaOe;
    wire logic [9:0] clkOut, clkOe, enables;
    logic [9:0] acks;
    int         n_errors = 0;
    int         checked = 0;
    // Open-drain data wire with pull-up
    assign sda = !(sdaLow || (sdaOe && !sdaOut));
    clock_fanout_ctrl clock_fanout_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .refClk(refClk), .outEnable(outEnable), .serial_clock_line(scl),
        .serial_data_line_in(sda), .serial_data_line_out(sdaOut), .serial_data_line_oe(sdaOe),
        .clock_outputs(clkOut), .clock_outputs_oe(clkOe), .outEnables(enables));
    bus_master_model bus_master_model_i (.scl(scl), .sdaLow(sdaLow), .sda(sda));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        refClk = 1'b0;
        forever #160 refClk = ~refClk;
    end
    task check(input logic [9:0] seen, input logic [9:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Frame started off the sampling edge, then settle time
    task send(input logic [79:0] d, input int n);
        @(negedge sys_clk);
        bus_master_model_i.frame(d, n, acks);
        repeat (8) @(posedge sys_clk);
    endtask
    task t_reset_pin;
        check(enables, 10'h3ff);
        outEnable <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check(clkOe, 10'h0);
        check(clkOut, 10'h0);
        outEnable <= 1'b1;
        repeat (6) @(posedge sys_clk);
        check(clkOe, 10'h3ff);
    endtask
    task t_wrong_addr;
        send({8'hd0, 72'h0}, 10);
        check(acks, 10'h0);
        check(enables, 10'h3ff);
    endtask
    task t_good;
        logic [9:0] seenHi;
        send({8'hd2, 16'hffff, 8'hf5, 8'h6f, 8'hbf, 32'hffffffff}, 10);
        check(acks, 10'h3ff);
        check(enables, 10'h265);
        seenHi = 10'h0;
        repeat (16) begin
            @(negedge sys_clk);
            seenHi |= clkOut;
        end
        check(seenHi, 10'h265);
    endtask
    task t_partial;
        send({8'hd2, 16'h0, 16'h0, 40'h0}, 5);
        check(enables, 10'h200);
    endtask
    // Reset, then scenarios in order
    initial begin
        sys_rst = 1'b1;
        outEnable = 1'b1;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_reset_pin;
        t_wrong_addr;
        t_good;
        t_partial;
        end_of_test;
    end
    // Hang guard
    initial begin
        #2000000;
        n_errors++;
        end_of_test;
    end
endmodule // tb_top
